// file: design/adc_host.sv
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic      [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            head;
        logic                        nonempty;
    } fifo_t;

    fifo_t fifo_ff;
    fifo_t nxt_fifo;
    logic  do_wr;
    logic  do_rd;

    always_comb
    begin
        nxt_fifo = fifo_ff;
        do_wr = i_wr_valid && (fifo_ff.count != (AW+1)'(DEPTH));
        do_rd = i_rd_ready && (fifo_ff.count != '0);
        if (do_wr)
        begin
            nxt_fifo.mem[fifo_ff.wp] = i_wr_data;
            nxt_fifo.wp = (fifo_ff.wp == AW'(DEPTH - 1)) ? '0 : fifo_ff.wp + 1'b1;
        end
        if (do_rd)
        begin
            nxt_fifo.rp = (fifo_ff.rp == AW'(DEPTH - 1)) ? '0 : fifo_ff.rp + 1'b1;
        end
        if (do_wr && !do_rd)
        begin
            nxt_fifo.count = fifo_ff.count + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            nxt_fifo.count = fifo_ff.count - 1'b1;
        end
        // Read side taken from next state: flopped outputs, no extra latency
        nxt_fifo.head = nxt_fifo.mem[nxt_fifo.rp];
        nxt_fifo.nonempty = (nxt_fifo.count != '0);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fifo_ff <= '0;
        end
        else
        begin
            fifo_ff <= nxt_fifo;
        end
    end

    assign o_wr_ready = fifo_ff.count != (AW+1)'(DEPTH);
    assign o_rd_valid = fifo_ff.nonempty;
    assign o_rd_data = fifo_ff.head;
endmodule : result_fifo

module adc_host
    import adc_pkg::*;
#(
    parameter int SCLK_HALF  = SCLK_HALF_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    adc_link_if.host              link,
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_clocks,
    output logic                  o_busy,
    output logic      [RES_W-1:0] o_data,
    output logic                  o_data_valid,
    input  wire logic             i_data_ready
);

    typedef struct packed {
        host_state_t      state;
        logic             busy;
        logic             cs_n;
        logic             sclk;
        logic [TMR_W-1:0] tmr;
        logic [CNT_W-1:0] clks;
        logic [CNT_W-1:0] target;
        logic             sd_s1;
        logic             sd_s2;
        logic [RES_W-1:0] word;
        logic             push;
    } host_t;

    host_t host_ff;
    host_t nxt_host;
    logic  push_ready;

    always_comb
    begin
        nxt_host = host_ff;
        nxt_host.sd_s1 = link.sdo;
        nxt_host.sd_s2 = host_ff.sd_s1;
        nxt_host.tmr = host_ff.tmr + 8'h01;
        case (host_ff.state)
            h_idle:
            begin
                nxt_host.tmr = '0;
                if (i_start)
                begin
                    nxt_host.busy = 1'b1;
                    nxt_host.cs_n = 1'b0;
                    nxt_host.clks = '0;
                    nxt_host.target = i_clocks;
                    nxt_host.word = ZERO_CODE;
                    nxt_host.state = h_high;
                end
            end
            h_high:
            begin
                if (host_ff.tmr == TMR_W'(SCLK_HALF - 1))
                begin
                    nxt_host.tmr = '0;
                    if (host_ff.clks == host_ff.target)
                    begin
                        nxt_host.cs_n = 1'b1;
                        nxt_host.push = host_ff.target >= CONV_CLKS;
                        nxt_host.state = (host_ff.target >= CONV_CLKS) ? h_push : h_gap;
                    end
                    else
                    begin
                        // Bit launched on the last rise is sampled before this fall
                        if (host_ff.clks >= FIRST_BIT_CLK && host_ff.clks <= LAST_BIT_CLK)
                        begin
                            nxt_host.word = {host_ff.word[RES_W-2:0], host_ff.sd_s2};
                        end
                        nxt_host.sclk = 1'b0;
                        nxt_host.clks = host_ff.clks + 7'h01;
                        nxt_host.state = h_low;
                    end
                end
            end
            h_low:
            begin
                if (host_ff.tmr == TMR_W'(SCLK_HALF - 1))
                begin
                    nxt_host.tmr = '0;
                    nxt_host.sclk = 1'b1;
                    nxt_host.state = h_high;
                end
            end
            h_push:
            begin
                // A full buffer holds the host here, so no frame starts
                nxt_host.tmr = '0;
                if (push_ready)
                begin
                    nxt_host.push = 1'b0;
                    nxt_host.state = h_gap;
                end
            end
            h_gap:
            begin
                if (host_ff.tmr >= TMR_W'(ACQUIRE_CYC - 1))
                begin
                    nxt_host.busy = 1'b0;
                    nxt_host.state = h_idle;
                end
            end
            default:
            begin
                nxt_host.state = h_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            host_ff.state <= h_idle;
            host_ff.busy <= 1'b0;
            host_ff.cs_n <= 1'b1;
            host_ff.sclk <= 1'b1;
            host_ff.tmr <= '0;
            host_ff.clks <= '0;
            host_ff.target <= '0;
            host_ff.sd_s1 <= 1'b0;
            host_ff.sd_s2 <= 1'b0;
            host_ff.word <= ZERO_CODE;
            host_ff.push <= 1'b0;
        end
        else
        begin
            host_ff <= nxt_host;
        end
    end

    result_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_wr_valid (host_ff.push),
        .o_wr_ready (push_ready),
        .i_wr_data  (host_ff.word),
        .o_rd_valid (o_data_valid),
        .i_rd_ready (i_data_ready),
        .o_rd_data  (o_data)
    );

    assign link.cs_n = host_ff.cs_n;
    assign link.sclk = host_ff.sclk;
    assign o_busy = host_ff.busy;

endmodule : adc_host

// file: design/adc_pkg.sv
package adc_pkg;
    localparam int              RES_W          = 14;
    localparam int              CNT_W          = 7;
    localparam int              TMR_W          = 8;
    localparam logic [CNT_W-1:0] CONV_CLKS     = 7'h12;
    localparam logic [CNT_W-1:0] CAL_START     = 7'h13;
    localparam logic [CNT_W-1:0] PWRUP_CAL_CLKS = 7'h18;
    localparam logic [CNT_W-1:0] RUN_CAL_CLKS  = 7'h40;
    localparam logic [CNT_W-1:0] CNT_MAX       = 7'h40;
    localparam logic [CNT_W-1:0] FIRST_BIT_CLK = 7'h01;
    localparam logic [CNT_W-1:0] LAST_BIT_CLK  = 7'h0e;
    localparam logic [RES_W-1:0] INVALID_CODE  = 14'h3fff;
    localparam logic [RES_W-1:0] ZERO_CODE     = 14'h0000;
    localparam int              CLK_NS         = 100;
    localparam int              ACQUIRE_NS     = 230;
    localparam int              ACQUIRE_CYC    = (ACQUIRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int              SCLK_HALF_DEF  = 8;
    localparam int              FIFO_DEPTH_DEF = 8;

    typedef enum logic [1:0] {
        acquire_state,
        convert_state,
        offset_calibrate_state
    } adc_state_t;

    typedef enum logic [2:0] {
        h_idle,
        h_high,
        h_low,
        h_push,
        h_gap
    } host_state_t;
endpackage : adc_pkg

// file: design/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic sdo_o;
    logic sdo_oe_n;
    logic sdo;

    // Released line reads low, as with a weak pull-down
    assign sdo = ~sdo_oe_n & sdo_o;

    modport dev (
        input  cs_n,
        input  sclk,
        output sdo_o,
        output sdo_oe_n
    );

    modport host (
        output cs_n,
        output sclk,
        input  sdo
    );
endinterface : adc_link_if

// file: design/adc_device.sv
`timescale 1ns/1ps
module adc_device
    import adc_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    adc_link_if.dev               link,
    input  wire logic [RES_W-1:0] i_sample,
    input  wire logic [RES_W-1:0] i_offset_meas,
    output logic      [RES_W-1:0] o_result,
    output logic                  o_result_valid,
    output logic      [RES_W-1:0] o_offset,
    output logic                  o_offset_valid,
    output logic                  o_isolate,
    output adc_state_t            o_state
);

    typedef struct packed {
        logic             cs_s1;
        logic             cs_s2;
        logic             cs_s3;
        logic             ck_s1;
        logic             ck_s2;
        logic             ck_s3;
        adc_state_t       state;
        logic             frame;
        logic             first;
        logic [CNT_W-1:0] cnt;
        logic [RES_W-1:0] sample;
        logic [RES_W-1:0] shreg;
        logic [RES_W-1:0] result;
        logic             result_valid;
        logic [RES_W-1:0] offset;
        logic             offset_valid;
        logic             isolate;
        logic             sdo;
        logic             oe_n;
    } dev_t;

    dev_t dev_ff;
    dev_t nxt_dev;

    logic             cs_fall;
    logic             cs_rise;
    logic             ck_fall;
    logic             ck_rise;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] cal_target;
    logic [RES_W-1:0] corrected;

    always_comb
    begin
        nxt_dev = dev_ff;
        nxt_dev.cs_s1 = link.cs_n;
        nxt_dev.cs_s2 = dev_ff.cs_s1;
        nxt_dev.cs_s3 = dev_ff.cs_s2;
        nxt_dev.ck_s1 = link.sclk;
        nxt_dev.ck_s2 = dev_ff.ck_s1;
        nxt_dev.ck_s3 = dev_ff.ck_s2;

        cs_fall = dev_ff.cs_s3 & ~dev_ff.cs_s2;
        cs_rise = ~dev_ff.cs_s3 & dev_ff.cs_s2;
        // Clock edges only count inside an open frame
        ck_fall = dev_ff.frame & dev_ff.ck_s3 & ~dev_ff.ck_s2;
        ck_rise = dev_ff.frame & ~dev_ff.ck_s3 & dev_ff.ck_s2;

        if (dev_ff.cnt != CNT_MAX)
        begin
            cnt_inc = dev_ff.cnt + 7'h01;
        end
        else
        begin
            cnt_inc = dev_ff.cnt;
        end

        if (dev_ff.first)
        begin
            cal_target = PWRUP_CAL_CLKS;
        end
        else
        begin
            cal_target = RUN_CAL_CLKS;
        end

        if (dev_ff.sample > dev_ff.offset)
        begin
            corrected = dev_ff.sample - dev_ff.offset;
        end
        else
        begin
            corrected = ZERO_CODE;
        end

        if (cs_rise)
        begin
            nxt_dev.oe_n = 1'b1;
            nxt_dev.sdo = 1'b0;
            nxt_dev.frame = 1'b0;
            nxt_dev.first = 1'b0;
            nxt_dev.cnt = '0;
            if (dev_ff.state == convert_state)
            begin
                nxt_dev.result = INVALID_CODE;
                nxt_dev.result_valid = 1'b0;
            end
            nxt_dev.state = acquire_state;
            nxt_dev.isolate = 1'b0;
        end
        else if (cs_fall)
        begin
            nxt_dev.state = convert_state;
            nxt_dev.frame = 1'b1;
            nxt_dev.cnt = '0;
            nxt_dev.sample = i_sample;
            nxt_dev.sdo = 1'b0;
            nxt_dev.oe_n = 1'b0;
            nxt_dev.shreg = dev_ff.result;
        end
        else
        begin
            if (ck_fall)
            begin
                nxt_dev.cnt = cnt_inc;
                if (dev_ff.state == convert_state && cnt_inc == CONV_CLKS)
                begin
                    nxt_dev.state = acquire_state;
                    nxt_dev.result = corrected;
                    nxt_dev.result_valid = 1'b1;
                end
                else if (dev_ff.state == acquire_state && cnt_inc == CAL_START)
                begin
                    nxt_dev.state = offset_calibrate_state;
                    nxt_dev.isolate = 1'b1;
                end
                else if (dev_ff.state == offset_calibrate_state
                         && cnt_inc == cal_target)
                begin
                    nxt_dev.offset = i_offset_meas;
                    nxt_dev.offset_valid = 1'b1;
                    nxt_dev.state = acquire_state;
                    nxt_dev.isolate = 1'b0;
                end
            end
            // A rise before the first fall launches nothing
            if (ck_rise && dev_ff.cnt != '0)
            begin
                nxt_dev.sdo = dev_ff.shreg[RES_W-1];
                nxt_dev.shreg = {dev_ff.shreg[RES_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            dev_ff.cs_s1 <= 1'b1;
            dev_ff.cs_s2 <= 1'b1;
            dev_ff.cs_s3 <= 1'b1;
            dev_ff.ck_s1 <= 1'b1;
            dev_ff.ck_s2 <= 1'b1;
            dev_ff.ck_s3 <= 1'b1;
            dev_ff.state <= acquire_state;
            dev_ff.frame <= 1'b0;
            dev_ff.first <= 1'b1;
            dev_ff.cnt <= '0;
            dev_ff.sample <= ZERO_CODE;
            dev_ff.shreg <= ZERO_CODE;
            dev_ff.result <= ZERO_CODE;
            dev_ff.result_valid <= 1'b0;
            dev_ff.offset <= ZERO_CODE;
            dev_ff.offset_valid <= 1'b0;
            dev_ff.isolate <= 1'b0;
            dev_ff.sdo <= 1'b0;
            dev_ff.oe_n <= 1'b1;
        end
        else
        begin
            dev_ff <= nxt_dev;
        end
    end

    assign link.sdo_o = dev_ff.sdo;
    assign link.sdo_oe_n = dev_ff.oe_n;
    assign o_result = dev_ff.result;
    assign o_result_valid = dev_ff.result_valid;
    assign o_offset = dev_ff.offset;
    assign o_offset_valid = dev_ff.offset_valid;
    assign o_isolate = dev_ff.isolate;
    assign o_state = dev_ff.state;

endmodule : adc_device

// file: test/adc_link_asserts.sv
`timescale 1ns/1ps
module adc_link_asserts (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdo_o,
    input  wire logic sdo_oe_n,
    input  wire logic sdo
);
    logic [4:0] age_ff;
    logic [6:0] rises_ff;
    logic       first_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Age saturates so a long idle never wraps into the launch window
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            age_ff   <= 5'h1f;
            rises_ff <= 7'h00;
            first_ff <= 1'b1;
        end
        else
        begin
            age_ff   <= $rose(sclk) ? 5'h00 : ((age_ff == 5'h1f) ? age_ff : age_ff + 5'h01);
            rises_ff <= cs_n ? 7'h00 : rises_ff + {6'h00, $rose(sclk)};
            first_ff <= first_ff & ~$rose(cs_n);
        end
    end

    sequence s_drive_zero;
        ##[3:5] (!sdo_oe_n && !sdo_o);
    endsequence
    sequence s_first_high;
        sclk [*8];
    endsequence

    property p_start_drive;
        $fell(cs_n) |-> s_drive_zero;
    endproperty
    property p_release;
        $rose(cs_n) |-> ##[3:5] sdo_oe_n;
    endproperty
    property p_idle_released;
        cs_n [*6] |-> sdo_oe_n;
    endproperty
    property p_frame_driven;
        !cs_n [*6] |-> !sdo_oe_n;
    endproperty
    property p_first_fall_wait;
        $fell(cs_n) |-> s_first_high;
    endproperty
    property p_low_half;
        $fell(sclk) |=> !sclk [*7];
    endproperty
    property p_no_idle_clock;
        cs_n && $past(cs_n) |-> !$fell(sclk);
    endproperty
    property p_bit_launch;
        !sdo_oe_n && !$fell(sdo_oe_n) && $changed(sdo_o) |-> age_ff >= 5'h02 && age_ff <= 5'h04;
    endproperty
    property p_tail_zero;
        !cs_n && rises_ff >= 7'h0f && age_ff == 5'h06 |-> !sdo_o;
    endproperty
    property p_first_zero;
        first_ff && !sdo_oe_n |-> !sdo;
    endproperty

    a_start_drive: assert property (p_start_drive)
        else $error("data line not driven low after frame start");
    a_release: assert property (p_release)
        else $error("data line not released after frame end");
    a_idle_released: assert property (p_idle_released)
        else $error("data line driven while deselected");
    a_frame_driven: assert property (p_frame_driven)
        else $error("data line released inside frame");
    a_first_fall_wait: assert property (p_first_fall_wait)
        else $error("serial clock fell too soon after frame start");
    a_low_half: assert property (p_low_half)
        else $error("serial clock low phase too short");
    a_no_idle_clock: assert property (p_no_idle_clock)
        else $error("serial clock fell while deselected");
    a_bit_launch: assert property (p_bit_launch)
        else $error("data bit changed away from a clock rise");
    a_tail_zero: assert property (p_tail_zero)
        else $error("nonzero bit after the result bits");
    a_first_zero: assert property (p_first_zero)
        else $error("nonzero bit in first frame");
endmodule : adc_link_asserts

// file: test/test_sar_adc_serial_frame_offset_cal.sv
`timescale 1ns/1ps
module test_sar_adc_serial_frame_offset_cal
    import adc_pkg::*;
;
    logic             i_clk;
    logic             i_resetn;
    logic [RES_W-1:0] sample, off_meas, sample2, res, offs, hdata, res2, offs2, bits;
    logic             res_v, offs_v, iso, hbusy, hvalid, start, ready, res_v2, offs_v2;
    logic [CNT_W-1:0] nclk;
    adc_state_t       st, st2, st_end;
    int               iso_cycles = 0;
    int               iso_mark;
    int               bad_count, num_checks;

    adc_link_if link();
    adc_link_if link2();

    adc_device i_adc_device (.i_clk(i_clk), .i_resetn(i_resetn), .link(link),
        .i_sample(sample), .i_offset_meas(off_meas), .o_result(res), .o_result_valid(res_v),
        .o_offset(offs), .o_offset_valid(offs_v), .o_isolate(iso), .o_state(st));
    adc_host i_adc_host (.i_clk(i_clk), .i_resetn(i_resetn), .link(link), .i_start(start),
        .i_clocks(nclk), .o_busy(hbusy), .o_data(hdata), .o_data_valid(hvalid),
        .i_data_ready(ready));
    // Second device faces the bench, which breaks the frame length on purpose
    adc_device i_adc_device_2 (.i_clk(i_clk), .i_resetn(i_resetn), .link(link2),
        .i_sample(sample2), .i_offset_meas(off_meas), .o_result(res2), .o_result_valid(res_v2),
        .o_offset(offs2), .o_offset_valid(offs_v2), .o_isolate(), .o_state(st2));
    adc_link_asserts i_adc_link_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
        .cs_n(link.cs_n), .sclk(link.sclk), .sdo_o(link.sdo_o), .sdo_oe_n(link.sdo_oe_n),
        .sdo(link.sdo));

    always #50 i_clk = ~i_clk;

    // Only grows, so scenarios compare against a mark instead of clearing it
    always @(posedge i_clk)
        if (iso === 1'b1)
            iso_cycles <= iso_cycles + 1;

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic check(input string name, input logic [RES_W-1:0] exp,
                         input logic [RES_W-1:0] got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (hbusy !== lvl && k < 2000)
        begin
            tick(1);
            k++;
        end
        check("busy", {13'h0, lvl}, {13'h0, hbusy});
    endtask : wait_busy

    task automatic start_frame(input logic [CNT_W-1:0] n);
        nclk = n;
        start = 1'b1;
        wait_busy(1'b1);
        start = 1'b0;
    endtask : start_frame

    task automatic frame(input logic [CNT_W-1:0] n);
        start_frame(n);
        wait_busy(1'b0);
    endtask : frame

    task automatic pop(input logic [RES_W-1:0] exp);
        tick(1);
        check("fifo valid", 14'h1, {13'h0, hvalid});
        check("fifo data", exp, hdata);
        ready = 1'b1;
        tick(1);
        ready = 1'b0;
    endtask : pop

    // Bench plays the host on the second link; bits taken late in each of the first RES_W high phases
    task automatic frame2(input int n);
        link2.cs_n = 1'b0;
        tick(8);
        for (int k = 1; k <= n; k++)
        begin
            link2.sclk = 1'b0;
            tick(8);
            link2.sclk = 1'b1;
            tick(8);
            if (k <= RES_W)
                bits = {bits[RES_W-2:0], link2.sdo};
        end
        st_end = st2;
        link2.cs_n = 1'b1;
        tick(8);
    endtask : frame2

    initial
    begin
        #(CLK_NS * 20000);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        wrap_up();
    end

    initial
    begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        sample = 14'h0abc;
        sample2 = 14'h0123;
        off_meas = 14'h0025;
        start = 1'b0;
        ready = 1'b0;
        nclk = CONV_CLKS;
        bad_count = 0;
        num_checks = 0;
        bits = 14'h0000;
        link2.cs_n = 1'b1;
        link2.sclk = 1'b1;
        tick(16);
        i_resetn = 1'b1;
        tick(2);
        check("state", {12'h0, acquire_state}, {12'h0, st});
        iso_mark = iso_cycles;
        frame(PWRUP_CAL_CLKS);
        check("offset", off_meas, offs);
        check("offset valid", 14'h1, {13'h0, offs_v});
        check("isolated", 14'h1, {13'h0, iso_cycles != iso_mark});
        check("state", {12'h0, acquire_state}, {12'h0, st});
        pop(ZERO_CODE);
        iso_mark = iso_cycles;
        sample = 14'h1234;
        frame(CONV_CLKS);
        pop(14'h0abc);
        check("result", 14'h120f, res);
        check("result valid", 14'h1, {13'h0, res_v});
        check("isolated", 14'h0, {13'h0, iso_cycles != iso_mark});
        off_meas = 14'h0003;
        sample = 14'h0010;
        frame(RUN_CAL_CLKS);
        pop(14'h120f);
        check("result", ZERO_CODE, res);
        check("offset", 14'h0003, offs);
        check("isolated", 14'h1, {13'h0, iso_cycles != iso_mark});
        sample = 14'h3fff;
        frame(CONV_CLKS);
        pop(ZERO_CODE);
        check("result", 14'h3ffc, res);
        sample = 14'h0100;
        for (int i = 0; i < FIFO_DEPTH_DEF; i++)
            frame(CONV_CLKS);
        start_frame(CONV_CLKS);
        tick(600);
        check("stalled", 14'h1, {13'h0, hbusy});
        pop(14'h3ffc);
        for (int i = 0; i < FIFO_DEPTH_DEF; i++)
            pop(14'h00fd);
        tick(2);
        check("fifo empty", 14'h0, {13'h0, hvalid});
        wait_busy(1'b0);
        frame2(20);
        check("cal entered", {12'h0, offset_calibrate_state}, {12'h0, st_end});
        check("state", {12'h0, acquire_state}, {12'h0, st2});
        check("offset valid", 14'h0, {13'h0, offs_v2});
        check("shifted", ZERO_CODE, bits);
        check("result", 14'h0123, res2);
        frame2(10);
        check("partial shift", 14'h0012, bits);
        check("short result", INVALID_CODE, res2);
        check("short valid", 14'h0, {13'h0, res_v2});
        check("state", {12'h0, acquire_state}, {12'h0, st2});
        frame2(30);
        check("cal entered", {12'h0, offset_calibrate_state}, {12'h0, st_end});
        check("shifted", INVALID_CODE, bits);
        check("offset valid", 14'h0, {13'h0, offs_v2});
        check("state", {12'h0, acquire_state}, {12'h0, st2});
        check("result", 14'h0123, res2);
        check("released", 14'h1, {13'h0, link2.sdo_oe_n});
        wrap_up();
    end
endmodule : test_sar_adc_serial_frame_offset_cal
